// ===== design/hsrp_port.sv
// Serial register port of the device: link shifter on sclk, core on ref_clk.
// Assumes mode-0 framing from the host, cs_n framing each transaction, and
// user logic on ref_clk answering forwarded reads.
`include "hsrp_map.svh"
`timescale 1ns/100ps

// Behaviour
// - Four wires; data-out pin also protocol strap
// - Register space is whole 32-bit words
// - Every field shifted MSB first
// - Zero reads, one writes; reads add turnaround
// - Read word follows turnaround, host sends zeros
// - Single and burst accesses after one header
// - Burst read: turnaround then successive words out
// - Whole words; trailing unused bytes ignored
// - Protocol chosen by sampled pins, not register
// - Link CRC enabled only by power-up strap
// - CRC-8, poly 0x07, zero seed
// - CRC after address and each control word
// - No per-word CRC in data transactions
// - Fields: read/write, readonly, writeonly, write-one-clear
// - Latch low, latch high, self clearing fields
// - PHY window accesses flagged on the forwarded request
module hsrp_port (
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire logic              sclk,
   input  wire logic              cs_n,
   input  wire logic              sdi,
   output logic                   sdo,
   output logic                   sdo_oe,
   input  wire logic              protocol_strap_pin,
   output logic                   acc_valid,
   output hsrp_pkg::hsrp_req_t    acc,
   input  wire logic [31:0]       user_rd_data,
   input  wire logic              user_rd_valid,
   input  wire logic              status_in,
   output logic                   crc_en,
   output logic                   link_err,
   output logic                   flush,
   output logic                   host_flag
);

   // ---------------------------------------------------------------
   // Address window decode
   // ---------------------------------------------------------------
   function automatic logic in_win(input logic [12:0] a, input logic [12:0] lo,
                                   input logic [12:0] hi);
      in_win = (a >= lo) && (a <= hi);
   endfunction : in_win

   // Link domain state
   hsrp_pkg::hsrp_lst_t st_ff, nxt_st;
   logic [5:0]          cnt_ff, nxt_cnt;
   logic [31:0]         rx_ff;
   logic [31:0]         tx_ff, nxt_tx;
   logic [31:0]         word_ff, nxt_word;
   logic [7:0]          crc_ff, nxt_crc;
   logic [7:0]          wcrc_ff, nxt_wcrc;
   logic [12:0]         addr_ff, nxt_addr;
   logic                rw_ff, nxt_rw;
   logic                bad_ff, nxt_bad;
   logic                sdo_ff, sdo_oe_ff;
   logic                fire, fire_wr, body, load, nxt_err;
   // Link domain, kept across frames
   logic                req_tgl_ff, err_tgl_ff;
   hsrp_pkg::hsrp_req_t req_ff, nxt_req;
   logic                ack_s1_ff, ack_s2_ff, crc_s1_ff, crc_s2_ff;
   // Core domain
   hsrp_pkg::hsrp_cst_t cst_ff;
   hsrp_pkg::hsrp_req_t acc_ff;
   logic                acc_valid_ff, ack_tgl_ff, link_err_ff, crc_en_ff;
   logic [31:0]         rdata_ff;
   logic                req_s1_ff, req_s2_ff, req_seen_ff;
   logic                err_s1_ff, err_s2_ff, err_seen_ff;
   logic                strap_s1_ff, strap_s2_ff;
   logic [1:0]          strap_age_ff;
   logic [6:0]          fld_q, fld_rbit, fld_hw;

   // ---------------------------------------------------------------
   // Link decode
   // ---------------------------------------------------------------
   wire        link_rst  = rst | cs_n;
   wire [31:0] rx_nxt    = {rx_ff[30:0], sdi};
   wire        last_bit  = (cnt_ff == 6'h00);
   wire        crc_on    = crc_s2_ff;
   wire        pending   = req_tgl_ff ^ ack_s2_ff;
   wire        addr_data = in_win(addr_ff, `HSRP_DATA_LO, `HSRP_DATA_HI);
   wire        word_crc  = crc_on & ~addr_data;
   wire [12:0] addr_step = addr_data ? 13'h0000 : 13'h0001;
   wire        hdr_ok    = (rx_nxt[15:14] == `HSRP_START_PAT);
   wire [31:0] ld_word   = pending ? 32'h0000_0000 : rdata_ff;
   wire        drive     = (st_ff == hsrp_pkg::L_RDATA) || (st_ff == hsrp_pkg::L_RCRC);
   wire        crc_keep  = ((st_ff == hsrp_pkg::L_HDR) && crc_on) ||
                           ((st_ff == hsrp_pkg::L_WDATA) && word_crc);
   wire [7:0]  crc_step;
   wire [7:0]  ld_crc;

   // Serial CRC over incoming bits and parallel CRC over outgoing word
   hsrp_crc8 #(.W(1)) u_crc_rx (
      .seed (crc_ff),
      .bits (sdi),
      .crc  (crc_step)
   );
   hsrp_crc8 #(.W(32)) u_crc_tx (
      .seed (`HSRP_CRC_SEED),
      .bits (ld_word),
      .crc  (ld_crc)
   );

   // ---------------------------------------------------------------
   // Link sequencer: header, CRC, turnaround, words
   // ---------------------------------------------------------------
   always_comb begin
      nxt_st   = st_ff;
      nxt_cnt  = cnt_ff - 6'h01;
      nxt_rw   = rw_ff;
      nxt_addr = addr_ff;
      nxt_bad  = bad_ff;
      nxt_word = word_ff;
      nxt_wcrc = wcrc_ff;
      nxt_tx   = {tx_ff[30:0], 1'b0};
      nxt_crc  = (last_bit && !crc_keep) ? `HSRP_CRC_SEED : crc_step;
      nxt_err  = 1'b0;
      fire     = 1'b0;
      fire_wr  = 1'b0;
      body     = 1'b0;
      load     = 1'b0;
      unique case (st_ff)
         hsrp_pkg::L_HDR: if (last_bit) begin
            nxt_rw   = rx_nxt[`HSRP_RW_POS];
            nxt_addr = rx_nxt[12:0];
            nxt_bad  = !hdr_ok;
            if (crc_on) begin
               nxt_st  = hsrp_pkg::L_HCRC;
               nxt_cnt = `HSRP_CRC_BITS - 6'h01;
            end else begin
               body = 1'b1;
            end
         end
         hsrp_pkg::L_HCRC: if (last_bit) begin
            nxt_bad = bad_ff | (crc_step != 8'h00);
            nxt_err = crc_step != 8'h00;
            body    = 1'b1;
         end
         hsrp_pkg::L_TA: if (last_bit) begin
            load = 1'b1;
         end
         hsrp_pkg::L_RDATA: begin
            if (cnt_ff == `HSRP_PREFETCH_CNT) begin
               fire     = 1'b1;
               nxt_addr = addr_ff + addr_step;
            end
            if (last_bit && word_crc) begin
               nxt_st  = hsrp_pkg::L_RCRC;
               nxt_cnt = `HSRP_CRC_BITS - 6'h01;
               nxt_tx  = {wcrc_ff, 24'h00_0000};
            end else if (last_bit) begin
               load = 1'b1;
            end
         end
         hsrp_pkg::L_RCRC: if (last_bit) begin
            load = 1'b1;
         end
         hsrp_pkg::L_WDATA: if (last_bit) begin
            nxt_word = rx_nxt;
            if (word_crc) begin
               nxt_st  = hsrp_pkg::L_WCRC;
               nxt_cnt = `HSRP_CRC_BITS - 6'h01;
            end else begin
               nxt_cnt = `HSRP_WORD_BITS - 6'h01;
               fire_wr = 1'b1;
            end
         end
         hsrp_pkg::L_WCRC: if (last_bit) begin
            nxt_st  = hsrp_pkg::L_WDATA;
            nxt_cnt = `HSRP_WORD_BITS - 6'h01;
            nxt_err = crc_step != 8'h00;
            fire_wr = crc_step == 8'h00;
         end
         hsrp_pkg::L_DROP: nxt_cnt = cnt_ff;
      endcase
      // Header done: drop if bad, else branch to read or write body
      if (body) begin
         if (nxt_bad) begin
            nxt_st = hsrp_pkg::L_DROP;
         end else if (nxt_rw == `HSRP_RW_READ) begin
            nxt_st  = hsrp_pkg::L_TA;
            nxt_cnt = `HSRP_TA_BITS - 6'h01;
            fire    = 1'b1;
         end else begin
            nxt_st  = hsrp_pkg::L_WDATA;
            nxt_cnt = `HSRP_WORD_BITS - 6'h01;
         end
      end
      // Next read word into the output shifter
      if (load) begin
         nxt_st   = hsrp_pkg::L_RDATA;
         nxt_cnt  = `HSRP_WORD_BITS - 6'h01;
         nxt_tx   = ld_word;
         nxt_wcrc = ld_crc;
         nxt_err  = pending;
      end
      fire = fire | fire_wr;
      // Request payload; writes step address after use
      nxt_req.write      = fire_wr;
      nxt_req.addr       = fire_wr ? addr_ff : nxt_addr;
      nxt_req.data       = nxt_word;
      nxt_req.phy        = in_win(nxt_req.addr, `HSRP_PHY_LO, `HSRP_PHY_HI);
      nxt_req.data_space = in_win(nxt_req.addr, `HSRP_DATA_LO, `HSRP_DATA_HI);
      if (fire_wr) begin
         nxt_addr = addr_ff + addr_step;
      end
      if (fire && pending) begin
         fire    = 1'b0;
         nxt_err = 1'b1;
      end
   end

   // Link registers, cleared whenever chip select is high
   always_ff @(posedge sclk or posedge link_rst) begin
      if (link_rst) begin
         st_ff   <= hsrp_pkg::L_HDR;
         cnt_ff  <= `HSRP_HDR_BITS - 6'h01;
         rx_ff   <= 32'h0000_0000;
         tx_ff   <= 32'h0000_0000;
         word_ff <= 32'h0000_0000;
         crc_ff  <= `HSRP_CRC_SEED;
         wcrc_ff <= 8'h00;
         addr_ff <= 13'h0000;
         rw_ff   <= 1'b0;
         bad_ff  <= 1'b0;
      end else begin
         st_ff   <= nxt_st;
         cnt_ff  <= nxt_cnt;
         rx_ff   <= rx_nxt;
         tx_ff   <= nxt_tx;
         word_ff <= nxt_word;
         crc_ff  <= nxt_crc;
         wcrc_ff <= nxt_wcrc;
         addr_ff <= nxt_addr;
         rw_ff   <= nxt_rw;
         bad_ff  <= nxt_bad;
      end
   end

   // Output pin changes on the falling edge
   always_ff @(negedge sclk or posedge link_rst) begin
      if (link_rst) begin
         sdo_ff    <= 1'b0;
         sdo_oe_ff <= 1'b0;
      end else begin
         sdo_ff    <= tx_ff[31];
         sdo_oe_ff <= drive;
      end
   end

   // Handshake side of the link; survives between frames
   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         req_tgl_ff <= 1'b0;
         err_tgl_ff <= 1'b0;
         req_ff     <= '0;
         ack_s1_ff  <= 1'b0;
         ack_s2_ff  <= 1'b0;
         crc_s1_ff  <= 1'b0;
         crc_s2_ff  <= 1'b0;
      end else begin
         ack_s1_ff  <= ack_tgl_ff;
         ack_s2_ff  <= ack_s1_ff;
         crc_s1_ff  <= crc_en_ff;
         crc_s2_ff  <= crc_s1_ff;
         req_tgl_ff <= req_tgl_ff ^ fire;
         err_tgl_ff <= err_tgl_ff ^ nxt_err;
         if (fire) begin
            req_ff <= nxt_req;
         end
      end
   end

   // ---------------------------------------------------------------
   // Core domain: strap, request service, local fields
   // ---------------------------------------------------------------
   wire new_req = (cst_ff == hsrp_pkg::C_IDLE) && (req_s2_ff != req_seen_ff);
   wire hit_st  = req_ff.addr == `HSRP_STATUS_ADDR;
   wire hit_cf  = req_ff.addr == `HSRP_CONFIG_ADDR;
   wire [31:0] loc_rdata = hit_st ? {28'h000_0000, fld_rbit[3:0]} :
                                    {29'h0000_0000, fld_rbit[6:4]};

   // Strap caught once, after the synchroniser settles
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         strap_s1_ff  <= 1'b0;
         strap_s2_ff  <= 1'b0;
         strap_age_ff <= 2'h0;
         crc_en_ff    <= 1'b0;
      end else begin
         strap_s1_ff <= protocol_strap_pin;
         strap_s2_ff <= strap_s1_ff;
         if (strap_age_ff != 2'h3) begin
            strap_age_ff <= strap_age_ff + 2'h1;
         end
         if (strap_age_ff == 2'h2) begin
            crc_en_ff <= strap_s2_ff;
         end
      end
   end

   // Request service and read return
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cst_ff       <= hsrp_pkg::C_IDLE;
         acc_ff       <= '0;
         acc_valid_ff <= 1'b0;
         ack_tgl_ff   <= 1'b0;
         rdata_ff     <= 32'h0000_0000;
         req_s1_ff    <= 1'b0;
         req_s2_ff    <= 1'b0;
         req_seen_ff  <= 1'b0;
         err_s1_ff    <= 1'b0;
         err_s2_ff    <= 1'b0;
         err_seen_ff  <= 1'b0;
         link_err_ff  <= 1'b0;
      end else begin
         req_s1_ff    <= req_tgl_ff;
         req_s2_ff    <= req_s1_ff;
         err_s1_ff    <= err_tgl_ff;
         err_s2_ff    <= err_s1_ff;
         err_seen_ff  <= err_s2_ff;
         link_err_ff  <= err_s2_ff ^ err_seen_ff;
         acc_valid_ff <= 1'b0;
         if (new_req) begin
            req_seen_ff <= req_s2_ff;
            if (hit_st || hit_cf) begin
               rdata_ff   <= loc_rdata;
               ack_tgl_ff <= ~ack_tgl_ff;
            end else if (req_ff.write) begin
               acc_valid_ff <= fld_q[`HSRP_FLD_WREN];
               ack_tgl_ff   <= ~ack_tgl_ff;
               if (fld_q[`HSRP_FLD_WREN]) begin
                  acc_ff <= req_ff;
               end
            end else begin
               acc_ff       <= req_ff;
               acc_valid_ff <= 1'b1;
               cst_ff       <= hsrp_pkg::C_WAIT;
            end
         end
         if ((cst_ff == hsrp_pkg::C_WAIT) && user_rd_valid) begin
            rdata_ff   <= user_rd_data;
            ack_tgl_ff <= ~ack_tgl_ff;
            cst_ff     <= hsrp_pkg::C_IDLE;
         end
      end
   end

   // Hardware inputs of the local fields
   assign fld_hw = {1'b0, fld_q[`HSRP_FLD_FLUSH], 1'b0, crc_en_ff, status_in, status_in,
                    link_err_ff};

   // Local status and config fields
   localparam hsrp_pkg::hsrp_access_t FLD_ACC [0:6] = '{
      hsrp_pkg::WRITE_ONE_CLEAR_ACCESS, hsrp_pkg::LATCH_HIGH_READONLY,
      hsrp_pkg::LATCH_LOW_READONLY, hsrp_pkg::READONLY, hsrp_pkg::READ_WRITE,
      hsrp_pkg::SELF_CLEARING_ACCESS, hsrp_pkg::WRITEONLY};
   localparam logic [6:0] FLD_RST = `HSRP_FLD_RST;

   for (genvar i = 0; i < 7; i++) begin : g_fld
      localparam int POS = (i < 4) ? i : i - 4;
      wire sel = (i < 4) ? hit_st : hit_cf;
      hsrp_field #(
         .ACC (FLD_ACC[i]),
         .RST (FLD_RST[i])
      ) u_fld (
         .clk   (ref_clk),
         .rst   (rst),
         .wr    (new_req & req_ff.write & sel),
         .rd    (new_req & ~req_ff.write & sel),
         .wbit  (req_ff.data[POS]),
         .hw_in (fld_hw[i]),
         .q     (fld_q[i]),
         .rbit  (fld_rbit[i])
      );
   end

   // Outputs, each from a flip-flop
   assign sdo       = sdo_ff;
   assign sdo_oe    = sdo_oe_ff;
   assign acc_valid = acc_valid_ff;
   assign acc       = acc_ff;
   assign crc_en    = crc_en_ff;
   assign link_err  = link_err_ff;
   assign flush     = fld_q[`HSRP_FLD_FLUSH];
   assign host_flag = fld_q[`HSRP_FLD_HFLAG];

endmodule : hsrp_port

// ===== inc/hsrp_map.svh
// Constants of the host serial register port: frame layout, CRC, address map.
// Definitions only; included by the port and CRC design files by bare name.
`ifndef HSRP_MAP_SVH
`define HSRP_MAP_SVH

// ---------------------------------------------------------------
// Frame layout (field lengths in link clock bits)
// ---------------------------------------------------------------
`define HSRP_HDR_BITS     6'h10
`define HSRP_CRC_BITS     6'h08
`define HSRP_TA_BITS      6'h08
`define HSRP_WORD_BITS    6'h20
`define HSRP_PREFETCH_CNT 6'h0F
`define HSRP_START_PAT    2'h2
`define HSRP_RW_POS       13
`define HSRP_RW_READ      1'h0

// ---------------------------------------------------------------
// Link CRC: x^8 + x^2 + x + 1, zero seed
// ---------------------------------------------------------------
`define HSRP_CRC_POLY     8'h07
`define HSRP_CRC_SEED     8'h00

// ---------------------------------------------------------------
// Address windows and local registers
// ---------------------------------------------------------------
`define HSRP_DATA_LO      13'h0030
`define HSRP_DATA_HI      13'h003F
`define HSRP_PHY_LO       13'h0800
`define HSRP_PHY_HI       13'h0FFF
`define HSRP_STATUS_ADDR  13'h1FF0
`define HSRP_CONFIG_ADDR  13'h1FF1

// Local field slots: 0..3 status bits 0..3, 4..6 config bits 0..2
`define HSRP_FLD_LINKERR  0
`define HSRP_FLD_STAT_HI  1
`define HSRP_FLD_STAT_LO  2
`define HSRP_FLD_STRAP    3
`define HSRP_FLD_WREN     4
`define HSRP_FLD_FLUSH    5
`define HSRP_FLD_HFLAG    6
`define HSRP_FLD_RST      7'h14

`endif

// ===== inc/hsrp_pkg.sv
// Types shared by the host serial register port design files.
// Assumes nothing of its surroundings.
package hsrp_pkg;

   // ---------------------------------------------------------------
   // Register field access kinds
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      READ_WRITE,
      READONLY,
      WRITEONLY,
      WRITE_ONE_CLEAR_ACCESS,
      LATCH_LOW_READONLY,
      LATCH_HIGH_READONLY,
      SELF_CLEARING_ACCESS
   } hsrp_access_t;

   // ---------------------------------------------------------------
   // One forwarded word access
   // ---------------------------------------------------------------
   typedef struct packed {
      logic        write;
      logic        phy;
      logic        data_space;
      logic [12:0] addr;
      logic [31:0] data;
   } hsrp_req_t;

   // Link side and core side states
   typedef enum logic [2:0] {L_HDR, L_HCRC, L_TA, L_RDATA, L_RCRC, L_WDATA, L_WCRC, L_DROP}
      hsrp_lst_t;
   typedef enum logic {C_IDLE, C_WAIT} hsrp_cst_t;

endpackage : hsrp_pkg

// ===== design/hsrp_crc8.sv
// Combinational CRC-8 over W bits, MSB first, from a given seed.
// Assumes hsrp_map.svh supplies the generator polynomial.
`include "hsrp_map.svh"
`timescale 1ns/100ps
module hsrp_crc8 #(
   parameter int W = 1
) (
   input  wire logic [7:0]   seed,
   input  wire logic [W-1:0] bits,
   output logic      [7:0]   crc
);

   // ---------------------------------------------------------------
   // Bitwise LFSR unrolled over the word
   // ---------------------------------------------------------------
   always_comb begin
      crc = seed;
      for (int i = W - 1; i >= 0; i--) begin
         crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ bits[i]) ? `HSRP_CRC_POLY : 8'h00);
      end
   end

endmodule : hsrp_crc8

// ===== design/hsrp_field.sv
// One register bit with a selectable access kind.
// Assumes wr/rd strobes are one-cycle pulses on clk.
`timescale 1ns/100ps
module hsrp_field #(
   parameter hsrp_pkg::hsrp_access_t ACC = hsrp_pkg::READ_WRITE,
   parameter logic                   RST = 1'b0
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic wr,
   input  wire logic rd,
   input  wire logic wbit,
   input  wire logic hw_in,
   output logic      q,
   output logic      rbit
);

   logic q_ff;
   logic nxt_q;

   // ---------------------------------------------------------------
   // Next value per access kind
   // ---------------------------------------------------------------
   always_comb begin
      unique case (ACC)
         hsrp_pkg::READ_WRITE,
         hsrp_pkg::WRITEONLY:              nxt_q = wr ? wbit : q_ff;
         hsrp_pkg::READONLY:               nxt_q = hw_in;
         hsrp_pkg::WRITE_ONE_CLEAR_ACCESS: nxt_q = hw_in | (q_ff & ~(wr & wbit));
         hsrp_pkg::LATCH_HIGH_READONLY:    nxt_q = hw_in | (q_ff & ~rd);
         hsrp_pkg::LATCH_LOW_READONLY:     nxt_q = hw_in & (q_ff | rd);
         hsrp_pkg::SELF_CLEARING_ACCESS:   nxt_q = (wr & wbit) | (q_ff & ~hw_in);
         default:                          nxt_q = q_ff;
      endcase
   end

   // Storage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q_ff <= RST;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign q    = q_ff;
   assign rbit = (ACC == hsrp_pkg::WRITEONLY) ? 1'b0 : q_ff;

endmodule : hsrp_field

// ===== verification/hsrp_port_asserts.sv
// Checker for the serial register port, bound to every hsrp_port.
// Assumes cs_n high clears the link side at once.
`timescale 1ns/100ps
module hsrp_port_asserts (
   input wire logic                ref_clk,
   input wire logic                rst,
   input wire logic                cs_n,
   input wire logic                sdo_oe,
   input wire logic                acc_valid,
   input wire hsrp_pkg::hsrp_req_t acc,
   input wire logic                crc_en,
   input wire logic                flush
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Pin release, forwarded access shape, flush pulse and strap hold
   a_oe_off_idle: assert property (cs_n |-> !sdo_oe)
      else $error("sdo driven while deselected");
   a_acc_pulse: assert property (acc_valid |=> !acc_valid [*2])
      else $error("acc_valid not a lone pulse");
   a_acc_holds: assert property (!acc_valid |-> $stable(acc))
      else $error("acc changed without acc_valid");
   a_phy_flag: assert property (acc_valid |->
      acc.phy == (acc.addr >= 13'h0800 && acc.addr <= 13'h0FFF)) else $error("bad phy flag");
   a_data_flag: assert property (acc_valid |->
      acc.data_space == (acc.addr >= 13'h0030 && acc.addr <= 13'h003F)) else $error("bad ds");
   a_no_local: assert property (acc_valid |-> acc.addr != 13'h1FF0 && acc.addr != 13'h1FF1)
      else $error("local register forwarded");
   a_flush_once: assert property (flush |=> !flush)
      else $error("flush longer than one cycle");
   a_strap_once: assert property (crc_en |=> crc_en)
      else $error("crc_en dropped without reset");
   // Main scenarios
   c_wr: cover property (acc_valid && acc.write);
   c_rd: cover property (acc_valid && !acc.write);
   c_fl: cover property (flush);
endmodule : hsrp_port_asserts
bind hsrp_port hsrp_port_asserts hsrp_port_asserts_inst (.*);

// ===== verification/hsrp_host.sv
// Host model: serial master, mode 0, 48 ns link clock.
// Assumes pin is the resolved level of the shared sdo pin.
`timescale 1ns/100ps
module hsrp_host (
   output logic      sclk,
   output logic      cs_n,
   output logic      sdi,
   input  wire logic pin
);
   initial {sclk, cs_n, sdi} = 3'h2;
   // One framed transfer, MSB first, clock still outside it
   task automatic xfer(input int n, input logic [127:0] tx, output logic [127:0] rx);
      cs_n = 0;
      for (int i = n - 1; i >= 0; i--) begin
         sdi = tx[i];
         #24 sclk = 1;
         rx[i] = pin;
         #24 sclk = 0;
      end
      #24 cs_n = 1;
      sdi = ~sdi;
   endtask : xfer
endmodule : hsrp_host

// ===== verification/tb.sv
// Testbench of hsrp_port against the host model.
// Assumes the user side answers reads one cycle after acc_valid.
`timescale 1ns/100ps
module tb;
   logic                ref_clk = 0, rst = 1, strap = 0, status_in = 0, user_rd_valid = 0;
   logic [31:0]         user_rd_data = 0;
   logic                sclk, cs_n, sdi, sdo, sdo_oe, acc_valid, crc_en, link_err, flush;
   logic                host_flag;
   hsrp_pkg::hsrp_req_t acc;
   hsrp_pkg::hsrp_req_t got[$];
   int                  fails = 0, num_checks = 0, nerr = 0, nfl = 0;
   wire                 pin = sdo_oe ? sdo : strap;
   always #25 ref_clk = ~ref_clk;
   hsrp_port hsrp_port_inst (.ref_clk, .rst, .sclk, .cs_n, .sdi, .sdo, .sdo_oe,
      .protocol_strap_pin(pin), .acc_valid, .acc, .user_rd_data, .user_rd_valid,
      .status_in, .crc_en, .link_err, .flush, .host_flag);
   hsrp_host hsrp_host_inst (.sclk, .cs_n, .sdi, .pin);
   // User side: log accesses, answer reads
   always @(posedge ref_clk) begin
      if (acc_valid) got.push_back(acc);
      nerr += link_err;
      nfl += flush;
      user_rd_valid <= acc_valid && !acc.write;
      user_rd_data <= {19'h0, acc.addr} ^ 32'h5A00_0000;
   end
   task chk(input string n, input logic [63:0] e, input logic [63:0] s);
      num_checks++;
      if (s !== e) begin
         fails++;
         $display("[FAIL] %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task settle;
      repeat (10) @(posedge ref_clk);
   endtask : settle
   task do_rst(input logic s);
      strap <= s;
      rst <= 1;
      repeat (2) @(posedge ref_clk);
      rst <= 0;
      repeat (6) @(posedge ref_clk);
      chk("crc_en", s, crc_en);
   endtask : do_rst
   function automatic logic [7:0] crc8(input logic [31:0] v, input int n);
      logic [7:0] c = 8'h00;
      for (int i = n - 1; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction : crc8
   // Single and burst writes, control, bridge and data space windows
   task t_write;
      logic [127:0] r;
      got.delete();
      hsrp_host_inst.xfer(48, {3'h5, 13'h0100, 32'hA5C3_0F1E}, r);
      settle;
      hsrp_host_inst.xfer(80, {3'h5, 13'h0810, 32'h1111_2222, 32'h3333_4444}, r);
      settle;
      hsrp_host_inst.xfer(80, {3'h5, 13'h0030, 32'h0043_0102, 32'h0300_0000}, r);
      settle;
      chk("nwr", 5, got.size());
      chk("w3", {3'h5, 13'h0030, 32'h0043_0102}, got[3]);
      chk("w4", {3'h5, 13'h0030, 32'h0300_0000}, got[4]);
      chk("w0", {3'h4, 13'h0100, 32'hA5C3_0F1E}, got[0]);
      chk("w1", {3'h6, 13'h0810, 32'h1111_2222}, got[1]);
      chk("w2", {3'h6, 13'h0811, 32'h3333_4444}, got[2]);
   endtask : t_write
   // Single control read and data space burst read
   task t_read;
      logic [127:0] r;
      hsrp_host_inst.xfer(56, {3'h4, 13'h0005, 40'h0}, r);
      settle;
      chk("rd", 32'h5A00_0005, r[31:0]);
      hsrp_host_inst.xfer(88, {3'h4, 13'h0030, 72'h0}, r);
      settle;
      chk("brd0", 32'h5A00_0030, r[63:32]);
      chk("brd1", 32'h5A00_0030, r[31:0]);
   endtask : t_read
   // Local config and status fields
   task t_cfg;
      logic [127:0] r;
      got.delete();
      nfl = 0;
      hsrp_host_inst.xfer(48, {3'h5, 13'h1FF1, 32'h7}, r);
      settle;
      chk("flush", 1, nfl);
      chk("hflag", 1, host_flag);
      hsrp_host_inst.xfer(56, {3'h4, 13'h1FF1, 40'h0}, r);
      settle;
      chk("cfg", 3'h1, r[2:0]);
      // One-cycle status pulse: latch-high catches it, latch-low stays low
      status_in <= 1'b1;
      @(posedge ref_clk);
      status_in <= 1'b0;
      hsrp_host_inst.xfer(56, {3'h4, 13'h1FF0, 40'h0}, r);
      settle;
      chk("stat", 0, r[3]);
      chk("latch", 3'h2, r[2:0]);
      chk("nloc", 1, got.size());
      chk("nloc_a", 13'h1FF2, got[0].addr);
   endtask : t_cfg
   // Strapped CRC: good write applied, bad word CRC dropped
   task t_crc;
      logic [127:0] r;
      logic [15:0]  h;
      h = {3'h5, 13'h0040};
      do_rst(1);
      got.delete();
      nerr = 0;
      hsrp_host_inst.xfer(64, {h, crc8(h, 16), 32'hC0DE_0001, crc8(32'hC0DE_0001, 32)}, r);
      settle;
      hsrp_host_inst.xfer(64, {h, crc8(h, 16), 32'hC0DE_0002, 8'h00}, r);
      settle;
      chk("ncrc", 1, got.size());
      chk("cw", {3'h4, 13'h0040, 32'hC0DE_0001}, got[0]);
      chk("lerr", 1, nerr);
   endtask : t_crc
   task print_verdict;
      if (fails == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : print_verdict
   // Main sequence and watchdog
   initial begin
      do_rst(0);
      t_write;
      t_read;
      t_cfg;
      t_crc;
      print_verdict;
   end
   initial begin
      #400000;
      fails++;
      print_verdict;
   end
endmodule : tb
